//--- bcs_pkg.sv
package bcs_pkg;
    // ------------------------------------------------------------
    // Region table
    // ------------------------------------------------------------
    localparam int NUM_REGIONS = 2;
    localparam logic REGION_BOOT = 1'b0;
    localparam logic REGION_DRAM = 1'b1;
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 16;
    localparam int WAIT_W = 4;
    // Values after reset
    localparam logic [15:0] BOOT_BASE_RST = 16'h0000;
    localparam logic [15:0] BOOT_MASK_RST = 16'h0000;
    localparam logic [WAIT_W-1:0] BOOT_WAITS_RST = 4'h3;
    localparam logic [WAIT_W-1:0] DRAM_WAITS_RST = 4'h0;
    localparam logic [15:0] DRAM_BASE_RST = 16'h0000;
    localparam logic [15:0] DRAM_MASK_RST = 16'h0000;

    // ------------------------------------------------------------
    // Bus monitor
    // ------------------------------------------------------------
    localparam int MON_W = 11;
    localparam logic [MON_W-1:0] MON_LIMIT_00 = 11'h400;
    localparam logic [MON_W-1:0] MON_LIMIT_01 = 11'h200;
    localparam logic [MON_W-1:0] MON_LIMIT_10 = 11'h100;
    localparam logic [MON_W-1:0] MON_LIMIT_11 = 11'h080;

    // ------------------------------------------------------------
    // Parallel port
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int TRACE_W = 4;

    typedef enum logic [1:0] {
        BCS_IDLE,
        BCS_WAIT,
        BCS_FIN
    } bcs_state_e;
endpackage : bcs_pkg

//--- bcs_par_port.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_par_port
    import bcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Configuration
    input wire logic [PORT_W-1:0] pin_assign_i,
    input wire logic [PORT_W-1:0] gpio_out_i,
    input wire logic [PORT_W-1:0] gpio_dir_i,
    // Trace sources
    input wire logic [TRACE_W-1:0] processor_status_i,
    input wire logic [TRACE_W-1:0] debug_data_i,
    // Pins
    input wire logic [PORT_W-1:0] port_in_i,
    output logic [PORT_W-1:0] port_o,
    output logic [PORT_W-1:0] port_oe_o,
    output logic [PORT_W-1:0] gpio_in_o
);
    logic [PORT_W-1:0] alt_val;

    // Low nibble carries status, high nibble debug data
    assign alt_val = {debug_data_i, processor_status_i};

    // Per-pin selection; alternate function always drives the pin
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            port_o <= '0;
            port_oe_o <= '0;
        end else begin
            port_o <= (pin_assign_i & alt_val) | (~pin_assign_i & gpio_out_i);
            port_oe_o <= pin_assign_i | gpio_dir_i;
        end
    end

    // Input capture
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gpio_in_o <= '0;
        end else begin
            gpio_in_o <= port_in_i;
        end
    end

    a_port_alt_sel: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !$past(srst_i) |-> (port_o & $past(pin_assign_i)) == ($past(alt_val) & $past(pin_assign_i))
            && ((port_oe_o & $past(pin_assign_i)) == $past(pin_assign_i)))
        else $error("alternate pin not carrying trace");
endmodule : bcs_par_port
`default_nettype wire

//--- bcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_top
    import bcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Processor bus cycle
    input wire logic transfer_start_i,
    input wire logic [31:0] addr_i,
    input wire logic rnw_i,
    output logic cycle_done_o,
    output logic transfer_error_o,
    output logic rnw_o,
    // Shared acknowledge line, open drain, active low
    input wire logic transfer_acknowledge_n_i,
    output logic transfer_acknowledge_n_o,
    output logic transfer_acknowledge_oe_o,
    // Chip selects, active low
    output logic boot_chip_select_n_o,
    output logic dram_select_n_o,
    // Region configuration strobe
    input wire logic cfg_wr_i,
    input wire logic cfg_sel_i,
    input wire logic [15:0] cfg_base_i,
    input wire logic [15:0] cfg_mask_i,
    input wire logic [WAIT_W-1:0] cfg_waits_i,
    input wire logic cfg_autoack_i,
    // Bus monitor control
    input wire logic monitor_en_i,
    input wire logic [1:0] monitor_timeout_select_i,
    // Parallel port
    input wire logic [PORT_W-1:0] pin_assign_i,
    input wire logic [PORT_W-1:0] gpio_out_i,
    input wire logic [PORT_W-1:0] gpio_dir_i,
    input wire logic [TRACE_W-1:0] processor_status_i,
    input wire logic [TRACE_W-1:0] debug_data_i,
    input wire logic [PORT_W-1:0] port_in_i,
    output logic [PORT_W-1:0] port_o,
    output logic [PORT_W-1:0] port_oe_o,
    output logic [PORT_W-1:0] gpio_in_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Mask bit set means the address bit is ignored
    function automatic logic region_hit(input logic [15:0] a, input logic [15:0] base,
                                        input logic [15:0] mask, input logic valid);
        region_hit = valid && (((a ^ base) & ~mask) == 16'h0000);
    endfunction : region_hit

    function automatic logic [MON_W-1:0] mon_limit(input logic [1:0] sel);
        case (sel)
            2'h0: mon_limit = MON_LIMIT_00;
            2'h1: mon_limit = MON_LIMIT_01;
            2'h2: mon_limit = MON_LIMIT_10;
            default: mon_limit = MON_LIMIT_11;
        endcase
    endfunction : mon_limit

    // ------------------------------------------------------------
    // Region storage
    // ------------------------------------------------------------
    logic [15:0] base_q [NUM_REGIONS];
    logic [15:0] mask_q [NUM_REGIONS];
    logic [WAIT_W-1:0] waits_q [NUM_REGIONS];
    logic autoack_q [NUM_REGIONS];
    logic valid_q [NUM_REGIONS];
    logic boot_global;

    // Table write; the boot entry resets to three waits with internal ack
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            base_q[REGION_BOOT] <= BOOT_BASE_RST;
            mask_q[REGION_BOOT] <= BOOT_MASK_RST;
            waits_q[REGION_BOOT] <= BOOT_WAITS_RST;
            autoack_q[REGION_BOOT] <= 1'b1;
            valid_q[REGION_BOOT] <= 1'b0;
            base_q[REGION_DRAM] <= DRAM_BASE_RST;
            mask_q[REGION_DRAM] <= DRAM_MASK_RST;
            waits_q[REGION_DRAM] <= DRAM_WAITS_RST;
            autoack_q[REGION_DRAM] <= 1'b1;
            valid_q[REGION_DRAM] <= 1'b0;
        end else if (cfg_wr_i) begin
            base_q[cfg_sel_i] <= cfg_base_i;
            mask_q[cfg_sel_i] <= cfg_mask_i;
            waits_q[cfg_sel_i] <= cfg_waits_i;
            autoack_q[cfg_sel_i] <= cfg_autoack_i;
            valid_q[cfg_sel_i] <= 1'b1;
        end
    end

    // Global boot decode, dropped by the first boot mask write only
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            boot_global <= 1'b1;
        end else if (cfg_wr_i && cfg_sel_i == REGION_BOOT) begin
            boot_global <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit_boot;
    logic hit_dram;
    logic sel_region;
    logic sel_any;

    // Boot wins when both match, so vectors stay reachable
    always_comb begin
        hit_boot = boot_global || region_hit(addr_i[ADDR_HI:ADDR_LO], base_q[REGION_BOOT],
                   mask_q[REGION_BOOT], valid_q[REGION_BOOT]);
        hit_dram = region_hit(addr_i[ADDR_HI:ADDR_LO], base_q[REGION_DRAM],
                   mask_q[REGION_DRAM], valid_q[REGION_DRAM]);
        sel_region = hit_boot ? REGION_BOOT : REGION_DRAM;
        sel_any = hit_boot || hit_dram;
    end

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    bcs_state_e state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] cur_waits;
    logic cur_autoack;
    logic [MON_W-1:0] age;
    logic [MON_W-1:0] cur_limit;
    logic cur_mon_en;
    logic ext_ack;

    // Our own drive must not be mistaken for a board's acknowledge
    assign ext_ack = !transfer_acknowledge_n_i && !transfer_acknowledge_oe_o;

    // State, counters and registered outputs of one bus cycle
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= BCS_IDLE;
            wait_cnt <= '0;
            cur_waits <= '0;
            cur_autoack <= 1'b0;
            age <= '0;
            cur_limit <= MON_LIMIT_00;
            cur_mon_en <= 1'b0;
            boot_chip_select_n_o <= 1'b1;
            dram_select_n_o <= 1'b1;
            transfer_acknowledge_oe_o <= 1'b0;
            cycle_done_o <= 1'b0;
            transfer_error_o <= 1'b0;
            rnw_o <= 1'b1;
        end else begin
            cycle_done_o <= 1'b0;
            transfer_error_o <= 1'b0;
            case (state)
                BCS_IDLE: begin
                    if (transfer_start_i) begin
                        // Zero waits acknowledge alongside the select, no extra cycle
                        if (sel_any && autoack_q[sel_region] && waits_q[sel_region] == '0) begin
                            state <= BCS_FIN;
                            transfer_acknowledge_oe_o <= 1'b1;
                        end else begin
                            state <= BCS_WAIT;
                        end
                        // The start edge counts as the first wait, so load one less
                        wait_cnt <= waits_q[sel_region] - 4'h1;
                        cur_waits <= waits_q[sel_region];
                        cur_autoack <= sel_any && autoack_q[sel_region];
                        age <= '0;
                        cur_limit <= mon_limit(monitor_timeout_select_i);
                        cur_mon_en <= monitor_en_i;
                        boot_chip_select_n_o <= !hit_boot;
                        dram_select_n_o <= hit_boot || !hit_dram;
                        rnw_o <= rnw_i;
                    end
                end
                BCS_WAIT: begin
                    if (ext_ack) begin
                        state <= BCS_IDLE;
                        cycle_done_o <= 1'b1;
                        boot_chip_select_n_o <= 1'b1;
                        dram_select_n_o <= 1'b1;
                    end else if (cur_autoack && wait_cnt == '0) begin
                        state <= BCS_FIN;
                        transfer_acknowledge_oe_o <= 1'b1;
                    end else if (cur_mon_en && age == cur_limit - 11'h001) begin
                        state <= BCS_IDLE;
                        transfer_error_o <= 1'b1;
                        boot_chip_select_n_o <= 1'b1;
                        dram_select_n_o <= 1'b1;
                    end else begin
                        if (wait_cnt != '0) begin
                            wait_cnt <= wait_cnt - 4'h1;
                        end
                        if (age != {MON_W{1'b1}}) begin
                            age <= age + 11'h001;
                        end
                    end
                end
                BCS_FIN: begin
                    state <= BCS_IDLE;
                    transfer_acknowledge_oe_o <= 1'b0;
                    cycle_done_o <= 1'b1;
                    boot_chip_select_n_o <= 1'b1;
                    dram_select_n_o <= 1'b1;
                end
                default: begin
                    state <= BCS_IDLE;
                    transfer_acknowledge_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // Driven level is always low; the board pull-up gives the high
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            transfer_acknowledge_n_o <= 1'b0;
        end else begin
            transfer_acknowledge_n_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Parallel port
    // ------------------------------------------------------------
    bcs_par_port u_port (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .pin_assign_i(pin_assign_i),
        .gpio_out_i(gpio_out_i),
        .gpio_dir_i(gpio_dir_i),
        .processor_status_i(processor_status_i),
        .debug_data_i(debug_data_i),
        .port_in_i(port_in_i),
        .port_o(port_o),
        .port_oe_o(port_oe_o),
        .gpio_in_o(gpio_in_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_boot_any_addr: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state == BCS_IDLE && transfer_start_i && boot_global |=> !boot_chip_select_n_o)
        else $error("boot select missed during global decode");

    a_global_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cfg_wr_i && cfg_sel_i == REGION_BOOT |=> !boot_global ##1 !boot_global)
        else $error("global boot decode survived mask write");

    a_dram_base: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state == BCS_IDLE && transfer_start_i && !hit_boot && hit_dram
        |=> !dram_select_n_o && boot_chip_select_n_o)
        else $error("dram region not selected");

    a_wait_count: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $rose(transfer_acknowledge_oe_o) |-> age == ((cur_waits == '0) ? 11'h000
            : {7'h00, cur_waits} - 11'h001))
        else $error("internal ack at wrong wait count");

    a_boot_waits: assert property (@(posedge clk_sys_i)
        $past(srst_i) && !srst_i |-> waits_q[REGION_BOOT] == 4'h3 && boot_global)
        else $error("boot defaults wrong after reset");

    a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        transfer_acknowledge_oe_o |=> !transfer_acknowledge_oe_o && cycle_done_o
            && boot_chip_select_n_o && dram_select_n_o)
        else $error("ack not a single cycle ending the transfer");

    a_ext_single: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state == BCS_WAIT && ext_ack |=> state == BCS_IDLE && !transfer_acknowledge_oe_o
            && cycle_done_o)
        else $error("external ack did not end cycle cleanly");

    a_monitor_time: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        transfer_error_o |-> age == cur_limit - 11'h001 && state == BCS_IDLE)
        else $error("transfer error at wrong time");
endmodule : bcs_top
`default_nettype wire

//--- bcs_exp_board.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Expansion board on the shared acknowledge line
// ------------------------------------------------------------
module bcs_exp_board
    import bcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Bus as seen on the connector
    input wire logic transfer_start_i,
    input wire logic [31:0] addr_i,
    // Behaviour chosen by the bench
    input wire logic enable_i,
    input wire logic [15:0] window_i,
    input wire logic [7:0] delay_i,
    // Open-collector pull, no pull-up of its own
    output logic ack_pull_o
);
    logic busy;
    logic [7:0] cnt;

    // Answer a decoded cycle after delay_i cycles; delay_i must be 2 or more
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            ack_pull_o <= 1'b0;
        end else begin
            ack_pull_o <= 1'b0;
            if (!busy && transfer_start_i && enable_i && addr_i[31:16] == window_i) begin
                busy <= 1'b1;
                cnt <= 8'h01;
            end else if (busy) begin
                if (cnt == delay_i - 8'h01) begin
                    ack_pull_o <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end
endmodule : bcs_exp_board
`default_nettype wire

//--- boot_chip_select_ack_gen_test.sv
`timescale 1ns/1ps
`default_nettype none
module boot_chip_select_ack_gen_test;
    import bcs_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i, ts, rnw, cfg_wr, cfg_sel, cfg_auto, mon_en, brd_en;
    logic [31:0] addr;
    logic [15:0] cfg_base, cfg_mask, brd_win;
    logic [WAIT_W-1:0] cfg_waits;
    logic [1:0] mon_sel;
    logic [7:0] brd_dly, pin_asg, g_out, g_dir, p_in;
    logic [3:0] pst, ddat;
    logic done, err, rnw_q, ack_n_o, ack_oe, boot_n, dram_n, ack_pull, ack_wire_n;
    logic [7:0] p_o, p_oe, g_in;
    int error_cnt = 0;
    int total_checks = 0;

    // Clock, 100 MHz
    always #5 clk_sys_i = ~clk_sys_i;
    // Wired acknowledge: pull-up on the base board, any party may pull low
    assign ack_wire_n = ~((ack_oe & ~ack_n_o) | ack_pull);

    bcs_top DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .transfer_start_i(ts), .addr_i(addr),
        .rnw_i(rnw), .cycle_done_o(done), .transfer_error_o(err), .rnw_o(rnw_q),
        .transfer_acknowledge_n_i(ack_wire_n), .transfer_acknowledge_n_o(ack_n_o),
        .transfer_acknowledge_oe_o(ack_oe), .boot_chip_select_n_o(boot_n),
        .dram_select_n_o(dram_n), .cfg_wr_i(cfg_wr), .cfg_sel_i(cfg_sel), .cfg_base_i(cfg_base),
        .cfg_mask_i(cfg_mask), .cfg_waits_i(cfg_waits), .cfg_autoack_i(cfg_auto),
        .monitor_en_i(mon_en), .monitor_timeout_select_i(mon_sel), .pin_assign_i(pin_asg),
        .gpio_out_i(g_out), .gpio_dir_i(g_dir), .processor_status_i(pst), .debug_data_i(ddat),
        .port_in_i(p_in), .port_o(p_o), .port_oe_o(p_oe), .gpio_in_o(g_in));
    bcs_exp_board board (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .transfer_start_i(ts),
        .addr_i(addr), .enable_i(brd_en), .window_i(brd_win), .delay_i(brd_dly),
        .ack_pull_o(ack_pull));

    // ------------------------------------------------------------
    // Comparison and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    task automatic cfg(input logic s, input logic [15:0] b, input logic [15:0] m,
                       input logic [3:0] w, input logic au);
        @(posedge clk_sys_i);
        cfg_wr <= 1'b1;
        cfg_sel <= s;
        cfg_base <= b;
        cfg_mask <= m;
        cfg_waits <= w;
        cfg_auto <= au;
        @(posedge clk_sys_i);
        cfg_wr <= 1'b0;
    endtask : cfg

    // One bus cycle; cycle numbers count edges from the start edge, which is cycle 1
    task automatic cyc(input logic [31:0] a, input logic r, input int e_oe, input int e_end,
                       input logic e_boot, input logic e_dram, input logic e_err);
        int k_oe;
        int n_oe;
        int k_end;
        logic bseen;
        logic dseen;
        logic eseen;
        k_oe = 0;
        n_oe = 0;
        k_end = 0;
        bseen = 1'b0;
        dseen = 1'b0;
        eseen = 1'b0;
        @(posedge clk_sys_i);
        ts <= 1'b1;
        addr <= a;
        rnw <= r;
        @(posedge clk_sys_i);
        ts <= 1'b0;
        for (int k = 1; k < 1100 && k_end == 0; k++) begin
            #1;
            if (k == 1) check(rnw_q, r);
            if (boot_n === 1'b0) bseen = 1'b1;
            if (dram_n === 1'b0) dseen = 1'b1;
            if (ack_oe === 1'b1) begin
                n_oe++;
                k_oe = k;
                check({ack_n_o, ack_wire_n}, 2'b00);
            end
            if (done === 1'b1 || err === 1'b1) begin
                k_end = k;
                eseen = err;
                check({boot_n, dram_n}, 2'b11);
            end
            @(posedge clk_sys_i);
        end
        check(k_oe, e_oe);
        check(n_oe, (e_oe != 0) ? 1 : 0);
        check(k_end, e_end);
        check({bseen, dseen, eseen}, {e_boot, e_dram, e_err});
    endtask : cyc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Boot select answers any address, three waits, until the mask is written
    task automatic t_boot();
        check({boot_n, dram_n, ack_oe, done, err, rnw_q}, 6'h31);
        cyc(32'h0000_0000, 1'b1, 4, 5, 1'b1, 1'b0, 1'b0);
        cyc(32'h0000_0004, 1'b1, 4, 5, 1'b1, 1'b0, 1'b0);
        cyc(32'h4000_0000, 1'b0, 4, 5, 1'b1, 1'b0, 1'b0);
        cyc(32'hfedc_0000, 1'b1, 4, 5, 1'b1, 1'b0, 1'b0);
    endtask : t_boot

    // Board acknowledge during the boot wait ends the cycle early, no internal ack
    task automatic t_early_ext();
        brd_en <= 1'b1;
        brd_win <= 16'h1230;
        brd_dly <= 8'h02;
        cyc(32'h1230_0000, 1'b1, 0, 3, 1'b1, 1'b0, 1'b0);
        brd_en <= 1'b0;
    endtask : t_early_ext

    // Programmed bases: flash high, dram at zero, others unselected
    task automatic t_decode();
        cfg(REGION_BOOT, 16'hffe0, 16'h000f, 4'h3, 1'b1);
        cfg(REGION_DRAM, 16'h0000, 16'h003f, 4'h1, 1'b1);
        cyc(32'hffe0_0000, 1'b1, 4, 5, 1'b1, 1'b0, 1'b0);
        cyc(32'h0000_0000, 1'b0, 2, 3, 1'b0, 1'b1, 1'b0);
        cyc(32'h003f_fffc, 1'b1, 2, 3, 1'b0, 1'b1, 1'b0);
        brd_en <= 1'b1;
        brd_win <= 16'h4000;
        brd_dly <= 8'h05;
        cyc(32'h4000_0000, 1'b1, 0, 6, 1'b0, 1'b0, 1'b0);
        // Region without internal ack waits for the board even when selected
        cfg(REGION_DRAM, 16'h0000, 16'h003f, 4'h1, 1'b0);
        brd_win <= 16'h0000;
        brd_dly <= 8'h03;
        cyc(32'h0000_0100, 1'b1, 0, 4, 1'b0, 1'b1, 1'b0);
        brd_en <= 1'b0;
    endtask : t_decode

    // Bus monitor ends an unanswered cycle with an error, every encoding;
    // the error flag shows on the edge after the last counted clock
    task automatic t_monitor();
        int lim [4] = '{1024, 512, 256, 128};
        mon_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            mon_sel <= i[1:0];
            cyc(32'h5000_0000, 1'b1, 0, lim[i] + 1, 1'b0, 1'b0, 1'b1);
        end
        mon_en <= 1'b0;
    endtask : t_monitor

    // Parallel port: trace alternate or general I/O per pin
    task automatic t_port();
        @(posedge clk_sys_i);
        pin_asg <= 8'h0f;
        pst <= 4'ha;
        ddat <= 4'h5;
        g_out <= 8'hc3;
        g_dir <= 8'h30;
        p_in <= 8'h96;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(p_oe, 8'h3f);
        check(p_o & p_oe, 8'h0a);
        check(g_in, 8'h96);
        @(posedge clk_sys_i);
        pin_asg <= 8'hff;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check({p_o, p_oe}, 16'h5aff);
    endtask : t_port

    // Mid-run reset brings the global boot decode back
    task automatic t_reset();
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1;
        check({boot_n, dram_n, ack_oe, done, err, rnw_q}, 6'h31);
        cyc(32'h4000_0000, 1'b1, 4, 5, 1'b1, 1'b0, 1'b0);
    endtask : t_reset

    // Inputs at time zero
    initial begin
        srst_i <= 1'b1;
        ts <= 1'b0;
        rnw <= 1'b1;
        addr <= 32'h0;
        cfg_wr <= 1'b0;
        cfg_sel <= 1'b0;
        cfg_base <= 16'h0;
        cfg_mask <= 16'h0;
        cfg_waits <= 4'h0;
        cfg_auto <= 1'b0;
        mon_en <= 1'b0;
        mon_sel <= 2'b00;
        brd_en <= 1'b0;
        brd_win <= 16'h0;
        brd_dly <= 8'h02;
        pin_asg <= 8'h0;
        g_out <= 8'h0;
        g_dir <= 8'h0;
        pst <= 4'h0;
        ddat <= 4'h0;
        p_in <= 8'h0;
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        t_boot();
        t_early_ext();
        t_decode();
        t_monitor();
        t_port();
        t_reset();
        complete_run();
    end

    // Watchdog, far beyond the roughly 2,000 cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule : boot_chip_select_ack_gen_test
`default_nettype wire
